// ===== led_mode_defs.vh
// Constants of the LED driver mode-control and event-flag block.
// Assumes inclusion by bare name from the block's design files.
`ifndef LED_MODE_DEFS_VH
`define LED_MODE_DEFS_VH

// --------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------
`define OFS_MODE_CONTROL 8'h01
`define OFS_EVENT_FLAGS  8'h02
`define OFS_IRQ_ENABLE   8'h03
`define OFS_CONFIG       8'h04
`define OFS_SINK_ENABLE  8'h10
`define OFS_CMP_CONFIG   8'h1b

// --------------------------------------------------------------
// Mode control fields
// --------------------------------------------------------------
`define MC_RETRIG        6
`define MC_ACTIVE        5
`define MC_DIM           4
`define MC_GDWN_BLOCK    3
`define MC_SYNC_SINK     2
`define MC_AUTO          1
`define MC_BL_ON         0
`define MC_MASK          8'h7f

// --------------------------------------------------------------
// Event flag fields
// --------------------------------------------------------------
`define EF_SHORT         4
`define EF_OVERTEMP      3
`define EF_OVERVOLT      2
`define EF_SENSOR2       1
`define EF_SENSOR1       0
`define EF_MASK          8'h1f
`define IE_MASK          8'h1f

// --------------------------------------------------------------
// Config and comparator fields
// --------------------------------------------------------------
`define CF_LEVEL_HI      4
`define CF_LEVEL_LO      3
`define CF_MASK          8'h7f
`define LVL_DAYLIGHT     2'h0
`define LVL_OFFICE       2'h1
`define LVL_DARK         2'h2
`define SINK_MASK        8'h7f
`define CC_OFFICE_ON     0
`define CC_DARK_ON       1
`define CC_OFFICE_OUT    2
`define CC_DARK_OUT      3
`define CC_WR_MASK       8'hf3

// --------------------------------------------------------------
// Reset values and timing
// --------------------------------------------------------------
`define RST_BYTE         8'h00
`define RETRIG_TIME_US   50
`define CLOCK_MHZ        25
`define RETRIG_CYCLES    (`RETRIG_TIME_US * `CLOCK_MHZ)

`endif

// ===== pin_sync3.v
// Three-stage synchroniser for a pin input.
// Assumes the pin is asynchronous to clock; output moves once stages two and three agree.
module pin_sync3 (
	input  wire clock,
	input  wire rst,
	input  wire pin,
	output reg  level_r
);

	reg s1_r;
	reg s2_r;
	reg s3_r;

	// --------------------------------------------------------------
	// Sampling chain
	// --------------------------------------------------------------
	always @(posedge clock) begin
		if (rst) begin
			s1_r    <= 1'b0;
			s2_r    <= 1'b0;
			s3_r    <= 1'b0;
			level_r <= 1'b0;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				level_r <= s3_r;
			end
		end
	end

endmodule

// ===== irq_holdoff.v
// Release timer of the host interrupt line.
// Assumes start is a one-cycle pulse on the block's clock.
`include "led_mode_defs.vh"

module irq_holdoff #(
	parameter CYCLES = `RETRIG_CYCLES
) (
	input  wire clock,
	input  wire rst,
	input  wire start,
	output wire busy
);

	reg [11:0] count_r;

	// --------------------------------------------------------------
	// Down counter
	// --------------------------------------------------------------
	always @(posedge clock) begin
		if (rst) begin
			count_r <= 12'h000;
		end else if (start) begin
			count_r <= CYCLES[11:0];
		end else if (count_r != 12'h000) begin
			count_r <= count_r - 12'h001;
		end
	end

	assign busy = (count_r != 12'h000);

endmodule

// ===== led_mode_ctrl.v
// Mode control and event flags of a charge-pump LED backlight driver.
// Assumes a one-cycle register port on clock; fault and comparator pins are asynchronous.
//
// Implementation choice: the address-and-strobe port.
`include "led_mode_defs.vh"

module led_mode_ctrl #(
	parameter RETRIG = `RETRIG_CYCLES
) (
	input  wire       clock,
	input  wire       rst,
	input  wire [7:0] addr,
	input  wire [7:0] wdata,
	input  wire       wr,
	input  wire       rd,
	output reg  [7:0] rdata_r,
	input  wire       short_detect,
	input  wire       overtemp_detect,
	input  wire       overvolt_detect,
	input  wire       sensor1_input,
	input  wire       sensor2_input,
	input  wire       office_level_cmp_out,
	input  wire       dark_level_cmp_out,
	input  wire       dim_timeout,
	input  wire       leds_all_off,
	output reg        active_not_standby,
	output reg        backlight_run,
	output reg        dim_run,
	output reg        pump_gain_down_ok,
	output reg        sync_sink_group_on,
	output reg  [1:0] brightness_level,
	output wire       host_irq_o,
	output reg        host_irq_oe
);

	// --------------------------------------------------------------
	// Level choice from comparator outputs
	// --------------------------------------------------------------
	function [1:0] level_pick;
		input office_on;
		input dark_on;
		input office_out;
		input dark_out;
		begin
			if (dark_on && dark_out) begin
				level_pick = `LVL_DARK;
			end else if (office_on && office_out) begin
				level_pick = `LVL_OFFICE;
			end else begin
				level_pick = `LVL_DAYLIGHT;
			end
		end
	endfunction

	// --------------------------------------------------------------
	// Write decode
	// --------------------------------------------------------------
	function wr_hit;
		input       strobe;
		input [7:0] a;
		input [7:0] ofs;
		begin
			wr_hit = strobe && (a == ofs);
		end
	endfunction

	// --------------------------------------------------------------
	// Storage
	// --------------------------------------------------------------
	reg  [7:0] mode_r;
	reg  [7:0] flags_r;
	reg  [7:0] flags_nxt;
	reg  [7:0] ien_r;
	reg  [7:0] config_r;
	reg  [7:0] sink_r;
	reg  [7:0] cmp_cfg_r;
	reg        sen1_prev_r;
	reg        sen2_prev_r;
	reg  [7:0] rd_nxt;
	reg  [7:0] set_vec;
	reg        clear_pulse_r;
	reg        holdoff_start;
	reg        active_nxt;
	reg        run_nxt;
	reg        dim_nxt;
	reg        gain_ok_nxt;
	reg        sync_nxt;
	reg  [1:0] level_nxt;

	wire       short_s;
	wire       overtemp_s;
	wire       overvolt_s;
	wire       sen1_s;
	wire       sen2_s;
	wire       office_s;
	wire       dark_s;
	wire       holdoff_busy;
	wire       wr_mode;
	wire       wr_flags;
	wire       wr_ien;
	wire       wr_config;
	wire       wr_sink;
	wire       wr_cmp;
	wire       pending;
	wire       auto_live;
	wire [1:0] auto_level;

	// --------------------------------------------------------------
	// Pin synchronisers
	// --------------------------------------------------------------
	pin_sync3 u_sync_short (
		.clock   (clock),
		.rst     (rst),
		.pin     (short_detect),
		.level_r (short_s)
	);

	pin_sync3 u_sync_temp (
		.clock   (clock),
		.rst     (rst),
		.pin     (overtemp_detect),
		.level_r (overtemp_s)
	);

	pin_sync3 u_sync_volt (
		.clock   (clock),
		.rst     (rst),
		.pin     (overvolt_detect),
		.level_r (overvolt_s)
	);

	pin_sync3 u_sync_sen1 (
		.clock   (clock),
		.rst     (rst),
		.pin     (sensor1_input),
		.level_r (sen1_s)
	);

	pin_sync3 u_sync_sen2 (
		.clock   (clock),
		.rst     (rst),
		.pin     (sensor2_input),
		.level_r (sen2_s)
	);

	pin_sync3 u_sync_office (
		.clock   (clock),
		.rst     (rst),
		.pin     (office_level_cmp_out),
		.level_r (office_s)
	);

	pin_sync3 u_sync_dark (
		.clock   (clock),
		.rst     (rst),
		.pin     (dark_level_cmp_out),
		.level_r (dark_s)
	);

	// --------------------------------------------------------------
	// Decode
	// --------------------------------------------------------------
	assign wr_mode   = wr_hit(wr, addr, `OFS_MODE_CONTROL);
	assign wr_flags  = wr_hit(wr, addr, `OFS_EVENT_FLAGS);
	assign wr_ien    = wr_hit(wr, addr, `OFS_IRQ_ENABLE);
	assign wr_config = wr_hit(wr, addr, `OFS_CONFIG);
	assign wr_sink   = wr_hit(wr, addr, `OFS_SINK_ENABLE);
	assign wr_cmp    = wr_hit(wr, addr, `OFS_CMP_CONFIG);

	// Automatic following needs at least one comparator enabled
	assign auto_live  = mode_r[`MC_AUTO] &&
		(cmp_cfg_r[`CC_OFFICE_ON] || cmp_cfg_r[`CC_DARK_ON]);
	assign auto_level = level_pick(cmp_cfg_r[`CC_OFFICE_ON], cmp_cfg_r[`CC_DARK_ON],
		office_s, dark_s);

	// --------------------------------------------------------------
	// Event sources
	// --------------------------------------------------------------
	always @* begin
		set_vec = 8'h00;
		set_vec[`EF_SHORT]    = short_s;
		set_vec[`EF_OVERTEMP] = overtemp_s;
		set_vec[`EF_OVERVOLT] = overvolt_s;
		set_vec[`EF_SENSOR2]  = sen2_s ^ sen2_prev_r;
		set_vec[`EF_SENSOR1]  = sen1_s ^ sen1_prev_r;
	end

	// Write one clears, set wins over a clear in the same cycle
	always @* begin
		flags_nxt = flags_r;
		if (wr_flags) begin
			flags_nxt = flags_r & ~wdata;
		end
		flags_nxt = (flags_nxt | set_vec) & `EF_MASK;
	end

	// --------------------------------------------------------------
	// Register writes
	// --------------------------------------------------------------
	always @(posedge clock) begin
		if (rst) begin
			mode_r      <= `RST_BYTE;
			flags_r     <= `RST_BYTE;
			ien_r       <= `RST_BYTE;
			config_r    <= `RST_BYTE;
			sink_r      <= `RST_BYTE;
			cmp_cfg_r   <= `RST_BYTE;
			sen1_prev_r <= 1'b0;
			sen2_prev_r <= 1'b0;
		end else begin
			sen1_prev_r <= sen1_s;
			sen2_prev_r <= sen2_s;
			flags_r     <= flags_nxt;
			if (wr_mode) begin
				mode_r <= wdata & `MC_MASK;
			end
			if (dim_timeout) begin
				mode_r[`MC_DIM] <= 1'b1;
			end
			if (wr_ien) begin
				ien_r <= wdata & `IE_MASK;
			end
			if (wr_config) begin
				config_r <= wdata & `CF_MASK;
			end
			if (auto_live) begin
				config_r[`CF_LEVEL_HI:`CF_LEVEL_LO] <= auto_level;
			end
			if (wr_sink) begin
				sink_r <= wdata & `SINK_MASK;
			end
			if (wr_cmp) begin
				cmp_cfg_r <= wdata & `CC_WR_MASK;
			end
		end
	end

	// --------------------------------------------------------------
	// Read port
	// --------------------------------------------------------------
	always @* begin
		case (addr)
		`OFS_MODE_CONTROL: begin
			rd_nxt = mode_r;
		end
		`OFS_EVENT_FLAGS: begin
			rd_nxt = flags_r;
		end
		`OFS_IRQ_ENABLE: begin
			rd_nxt = ien_r;
		end
		`OFS_CONFIG: begin
			rd_nxt = config_r;
		end
		`OFS_SINK_ENABLE: begin
			rd_nxt = sink_r;
		end
		`OFS_CMP_CONFIG: begin
			rd_nxt = cmp_cfg_r;
			rd_nxt[`CC_OFFICE_OUT] = office_s;
			rd_nxt[`CC_DARK_OUT]   = dark_s;
		end
		default: begin
			rd_nxt = 8'h00;
		end
		endcase
	end

	// Reading has no side effect on the flags
	always @(posedge clock) begin
		if (rst) begin
			rdata_r <= 8'h00;
		end else if (rd) begin
			rdata_r <= rd_nxt;
		end else begin
			rdata_r <= 8'h00;
		end
	end

	// --------------------------------------------------------------
	// Host interrupt line
	// --------------------------------------------------------------
	assign pending = |(flags_r & ien_r);

	always @(posedge clock) begin
		if (rst) begin
			clear_pulse_r <= 1'b0;
		end else begin
			clear_pulse_r <= wr_flags && (|(wdata & `EF_MASK));
		end
	end

	// Timer starts only for a clear that leaves enabled events pending
	always @* begin
		holdoff_start = clear_pulse_r && pending && mode_r[`MC_RETRIG];
	end

	irq_holdoff #(
		.CYCLES (RETRIG)
	) u_holdoff (
		.clock (clock),
		.rst   (rst),
		.start (holdoff_start),
		.busy  (holdoff_busy)
	);

	assign host_irq_o = 1'b0;

	always @(posedge clock) begin
		if (rst) begin
			host_irq_oe <= 1'b0;
		end else begin
			host_irq_oe <= pending && !holdoff_busy && !holdoff_start;
		end
	end

	// --------------------------------------------------------------
	// Operating outputs
	// --------------------------------------------------------------
	always @* begin
		active_nxt  = mode_r[`MC_ACTIVE];
		run_nxt     = mode_r[`MC_ACTIVE] && mode_r[`MC_BL_ON];
		dim_nxt     = run_nxt && mode_r[`MC_DIM];
		gain_ok_nxt = !mode_r[`MC_GDWN_BLOCK] || leds_all_off;
		sync_nxt    = mode_r[`MC_ACTIVE] && mode_r[`MC_SYNC_SINK] &&
			(sink_r == 8'h00);
		level_nxt   = config_r[`CF_LEVEL_HI:`CF_LEVEL_LO];
	end

	always @(posedge clock) begin
		if (rst) begin
			active_not_standby <= 1'b0;
			backlight_run      <= 1'b0;
			dim_run            <= 1'b0;
			pump_gain_down_ok  <= 1'b1;
			sync_sink_group_on <= 1'b0;
			brightness_level   <= `LVL_DAYLIGHT;
		end else begin
			active_not_standby <= active_nxt;
			backlight_run      <= run_nxt;
			dim_run            <= dim_nxt;
			pump_gain_down_ok  <= gain_ok_nxt;
			sync_sink_group_on <= sync_nxt;
			brightness_level   <= level_nxt;
		end
	end

endmodule

// ===== led_mode_monitor.sv
// Port-level assertions for the mode-control and event-flag block.
// Assumes a bind onto led_mode_ctrl; shadows its mode, interrupt-enable and sink registers from port writes.
module led_mode_monitor #(
	parameter RETRIG = 20
) (
	input wire       clock,
	input wire       rst,
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire       wr,
	input wire       rd,
	input wire [7:0] rdata_r,
	input wire       leds_all_off,
	input wire       dim_timeout,
	input wire       active_not_standby,
	input wire       backlight_run,
	input wire       dim_run,
	input wire       pump_gain_down_ok,
	input wire       sync_sink_group_on,
	input wire       host_irq_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------
	// Shadow registers
	// ----------------
	reg [7:0] mode_r;
	reg [4:0] ien_r;
	reg [6:0] sink_r;
	always @(posedge clock) begin
		if (rst) begin
			mode_r <= 8'h00;
			ien_r  <= 5'h00;
			sink_r <= 7'h00;
		end else begin
			if (wr) begin
				case (addr)
				8'h01: mode_r <= wdata & 8'h7f;
				8'h03: ien_r <= wdata[4:0];
				8'h10: sink_r <= wdata[6:0];
				default: ;
				endcase
			end
			if (dim_timeout) begin
				mode_r[4] <= 1'b1;
			end
		end
	end
	// ----------------
	// Assertions
	// ----------------
	property p_standby;
		@(posedge clock) disable iff (rst) active_not_standby == $past(mode_r[5]);
	endproperty
	a_standby: assert property (p_standby) else $error("active output wrong");
	property p_run;
		@(posedge clock) disable iff (rst) backlight_run == $past(mode_r[0] & mode_r[5]);
	endproperty
	a_run: assert property (p_run) else $error("backlight run wrong");
	property p_dim;
		@(posedge clock) disable iff (rst) dim_run == $past(mode_r[4] & mode_r[0] & mode_r[5]);
	endproperty
	a_dim: assert property (p_dim) else $error("dim without backlight");
	property p_gain;
		@(posedge clock) disable iff (rst)
			pump_gain_down_ok == $past(!mode_r[3] | leds_all_off);
	endproperty
	a_gain: assert property (p_gain) else $error("gain-down permit wrong");
	property p_sync;
		@(posedge clock) disable iff (rst)
			sync_sink_group_on == $past(mode_r[2] & mode_r[5] & (sink_r == 7'h00));
	endproperty
	a_sync: assert property (p_sync) else $error("sync sink output wrong");
	property p_mask;
		@(posedge clock) disable iff (rst)
			(ien_r == 5'h00) && ($past(ien_r) == 5'h00) |-> !host_irq_oe;
	endproperty
	a_mask: assert property (p_mask) else $error("interrupt with all masked");
	property p_retrig;
		@(posedge clock) disable iff (rst)
			wr && addr == 8'h02 && wdata != 8'h00 && mode_r[6] |-> ##3 !host_irq_oe;
	endproperty
	a_retrig: assert property (p_retrig) else $error("line not released");
	property p_resv;
		@(posedge clock) disable iff (rst) $past(rd) |->
			!(($past(addr) == 8'h01 && rdata_r[7]) ||
			($past(addr) == 8'h02 && rdata_r[7:5] != 3'h0));
	endproperty
	a_resv: assert property (p_resv) else $error("reserved bit read as one");
endmodule

bind led_mode_ctrl led_mode_monitor #(.RETRIG(RETRIG)) led_mode_monitor_inst (
	.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata_r(rdata_r), .leds_all_off(leds_all_off), .dim_timeout(dim_timeout),
	.active_not_standby(active_not_standby), .backlight_run(backlight_run),
	.dim_run(dim_run), .pump_gain_down_ok(pump_gain_down_ok),
	.sync_sink_group_on(sync_sink_group_on), .host_irq_oe(host_irq_oe)
);

// ===== host_irq_pullup.sv
// Host side of the interrupt line: open-drain wire with a pull-up.
// Assumes the device pulls the line only while its enable is high.
module host_irq_pullup (
	input  wire oe,
	input  wire o,
	output wire level
);
	timeunit 1ns;
	timeprecision 1ns;
	assign level = oe ? o : 1'b1;
endmodule

// ===== tb.sv
// Self-checking bench for the mode-control and event-flag block.
// Assumes the design, its monitor and the host line model compile first.
`define CHK(n, e, g) chk(n, 8'(e), 8'(g))
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int RT = 20;
	logic       clock = 1'b0;
	logic       rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [4:0] ev = 5'h00;
	logic       dark_out = 1'b0;
	logic       office_out = 1'b0;
	logic       dim_timeout = 1'b0;
	logic       leds_all_off = 1'b0;
	wire  [7:0] rdata_r;
	wire  [1:0] level;
	wire        active, bl_run, dim_on, gain_ok, sync_on, irq_o, irq_oe, irq_level;
	int         n_mismatch = 0;
	int         num_checks = 0;
	int         cyc = 0;
	logic [7:0] mt [5] = '{8'h7f, 8'h11, 8'h30, 8'h21, 8'h2c};
	logic [4:0] et [5] = '{5'h1d, 5'h02, 5'h12, 5'h1a, 5'h11};
	// ----------------
	// Design and host line
	// ----------------
	led_mode_ctrl #(.RETRIG(RT)) led_mode_ctrl_inst (
		.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata_r(rdata_r), .short_detect(ev[4]), .overtemp_detect(ev[3]),
		.overvolt_detect(ev[2]), .sensor2_input(ev[1]), .sensor1_input(ev[0]),
		.office_level_cmp_out(office_out), .dark_level_cmp_out(dark_out),
		.dim_timeout(dim_timeout), .leds_all_off(leds_all_off),
		.active_not_standby(active), .backlight_run(bl_run), .dim_run(dim_on),
		.pump_gain_down_ok(gain_ok), .sync_sink_group_on(sync_on),
		.brightness_level(level), .host_irq_o(irq_o), .host_irq_oe(irq_oe)
	);
	host_irq_pullup host_irq_pullup_inst (.oe(irq_oe), .o(irq_o), .level(irq_level));
	always #20 clock = ~clock;
	// ----------------
	// Tasks
	// ----------------
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		`CHK(n, e, rdata_r);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			end_sim();
		end
	end
	// ----------------
	// Tests
	// ----------------
	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		rd_chk("mode", 8'h01, 8'h00);
		rd_chk("unmapped", 8'h7e, 8'h00);
		wr_reg(8'h01, 8'hff);
		rd_chk("mode", 8'h01, 8'h7f);
		wr_reg(8'h02, 8'hff);
		rd_chk("flags", 8'h02, 8'h00);
		for (int i = 0; i < 5; i++) begin
			wr_reg(8'h01, mt[i]);
			wait_n(2);
			`CHK("outputs", et[i], {active, bl_run, dim_on, gain_ok, sync_on});
		end
		@(posedge clock);
		leds_all_off <= 1'b1;
		wait_n(2);
		`CHK("gain_ok", 1, gain_ok);
		@(posedge clock);
		leds_all_off <= 1'b0;
		wr_reg(8'h01, 8'h24);
		wait_n(2);
		`CHK("sync", 1, sync_on);
		`CHK("gain_ok", 1, gain_ok);
		wr_reg(8'h10, 8'h01);
		wait_n(2);
		`CHK("sync", 0, sync_on);
		wr_reg(8'h10, 8'h00);
		wr_reg(8'h01, 8'h21);
		@(posedge clock);
		dim_timeout <= 1'b1;
		@(posedge clock);
		dim_timeout <= 1'b0;
		rd_chk("mode", 8'h01, 8'h31);
		wait_n(1);
		`CHK("dim", 1, dim_on);
		wr_reg(8'h04, 8'h08);
		wr_reg(8'h1b, 8'h03);
		dark_out <= 1'b1;
		wait_n(8);
		`CHK("level", 1, level);
		wr_reg(8'h01, 8'h23);
		wait_n(3);
		`CHK("level", 2, level);
		rd_chk("config", 8'h04, 8'h10);
		@(posedge clock);
		dark_out <= 1'b0;
		office_out <= 1'b1;
		wait_n(8);
		`CHK("level", 1, level);
		wr_reg(8'h01, 8'h20);
		for (int i = 0; i < 5; i++) begin
			@(posedge clock);
			ev[i] <= 1'b1;
			wait_n(8);
			@(posedge clock);
			ev[i] <= 1'b0;
			wait_n(8);
			rd_chk("flags", 8'h02, 8'((8'h02 << i) - 8'h01));
		end
		`CHK("irq line", 1, irq_level);
		wr_reg(8'h02, 8'h00);
		rd_chk("flags", 8'h02, 8'h1f);
		rd_chk("flags", 8'h02, 8'h1f);
		wr_reg(8'h03, 8'h1f);
		wait_n(3);
		`CHK("irq line", 0, irq_level);
		wr_reg(8'h02, 8'h1f);
		rd_chk("flags", 8'h02, 8'h00);
		wait_n(2);
		`CHK("irq line", 1, irq_level);
		@(posedge clock);
		ev[4] <= 1'b1;
		wait_n(10);
		wr_reg(8'h02, 8'h10);
		for (int i = 0; i < 10; i++) begin
			wait_n(1);
			`CHK("irq line", 0, irq_level);
		end
		wr_reg(8'h01, 8'h60);
		wr_reg(8'h02, 8'h10);
		wait_n(3);
		`CHK("irq line", 1, irq_level);
		wait_n(RT - 8);
		`CHK("irq line", 1, irq_level);
		for (int i = 0; i < 20 && irq_level; i++)
			wait_n(1);
		`CHK("irq line", 0, irq_level);
		@(posedge clock);
		ev[4] <= 1'b0;
		wait_n(8);
		wr_reg(8'h02, 8'h1f);
		wait_n(3);
		`CHK("irq line", 1, irq_level);
		end_sim();
	end
endmodule
